// File: hw/cfi_pkg.sv
package cfi_pkg;
  // Flag register layout
  localparam int FLAG_W = 8;
  localparam int BIT_CARRY = 0;
  localparam int BIT_ZERO = 1;
  localparam int BIT_NEG = 2;
  localparam int BIT_MASK = 3;
  localparam int BIT_HALF = 4;
  localparam logic [7:0] FLAGS_ONES = 8'he0;
  // Undefined flags come out of reset as one, as does the mask
  localparam logic [7:0] FLAGS_RESET = 8'he8;
  localparam int N_SRC = 8;
  localparam int ADDR_W = 16;
  // Flag operations requested by the execution datapath
  typedef enum logic [3:0] {
    CFI_OP_NONE,
    CFI_OP_ADD,
    CFI_OP_LOGIC,
    CFI_OP_SHIFT,
    CFI_OP_BTJ,
    CFI_OP_SET_CARRY,
    CFI_OP_RESET_CARRY,
    CFI_OP_SET_MASK,
    CFI_OP_CLEAR_MASK,
    CFI_OP_POP,
    CFI_OP_RETURN_FROM_ISR_INSTR
  } cfi_op_t;
endpackage : cfi_pkg

// File: hw/cfi_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] Eight-bit flag register, upper three bits one, mask set after reset.
// [RULE2] Whole flag byte can be pushed and popped; bits changed by instructions.
// [RULE3] Add instructions set half carry on carry from bit 3 into 4.
// [RULE4] Mask set on entry and by set-mask; cleared by clear-mask or return.
// [RULE5] Requests arriving while masked stay latched until mask clears.
// [RULE6] Clearing mask inside a routine services pending requests immediately.
// [RULE7] Negative flag copies bit 7 of the result after data operations.
// [RULE8] Zero flag set when the eight-bit result is zero.
// [RULE9] Carry records overflow, set/reset by instructions, shifts and bit tests.
// [RULE10] Current instruction completes before the interrupt is taken.
// [RULE11] Entry pushes program counter, index, accumulator and flags.
// [RULE12] After saving, mask set and program counter loaded with the vector.
// [RULE13] Return restores saved registers, leaving mask clear, and resumes.
// [RULE14] After reset all maskable interrupts are disabled.
// [RULE15] Simultaneous requests are chosen by fixed hardware priority.
// [RULE16] Any interrupt wakes from wait; only designated sources wake from halt.
// [RULE17] Software trap always enters the interrupt sequence regardless of mask.
// [RULE18] External request vectors only when mask clear; it also wakes halt. Here only HALT_WAKE sources (0 and 1 by default) wake halt.
// [RULE19] Edge external requests latch and clear on entry to their routine.
// [RULE20] Any low configured pin in a NAND group suppresses its request.
// [RULE21] Peripheral flag interrupts only when mask clear and enable set.
// [RULE22] Writing zero or the status-then-associated access clears a request.
// [RULE23] Vectors, priority and halt-wake sources are design parameters. Here priority is fixed by source index, not a parameter.
module cfi_core #(
  parameter int NSRC = cfi_pkg::N_SRC,
  // Lower index wins
  parameter logic [cfi_pkg::N_SRC-1:0] HALT_WAKE = 8'h03,
  parameter logic [cfi_pkg::N_SRC-1:0] EDGE_SRC = 8'h03,
  parameter logic [cfi_pkg::ADDR_W-1:0] VEC_BASE = 16'hffe0,
  parameter logic [cfi_pkg::ADDR_W-1:0] TRAP_VEC = 16'hfffc
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire cfi_pkg::cfi_op_t i_op,
  input wire logic [7:0] i_result,
  input wire logic i_carry,
  input wire logic i_half,
  input wire logic [7:0] i_pop_flags,
  input wire logic i_instr_done,
  input wire logic i_trap,
  input wire logic i_wait_mode,
  input wire logic i_halt_mode,
  input wire logic [cfi_pkg::N_SRC-1:0] i_ext_irq_source,
  input wire logic [3:0] i_nand_pins,
  input wire logic [3:0] i_nand_irq_cfg,
  input wire logic [cfi_pkg::N_SRC-1:0] i_periph_flag,
  input wire logic [cfi_pkg::N_SRC-1:0] i_periph_en,
  input wire logic [cfi_pkg::N_SRC-1:0] i_periph_clr,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_index,
  input wire logic [7:0] i_acc,
  output logic [7:0] o_condition_flags,
  output logic o_entry,
  output logic [cfi_pkg::ADDR_W-1:0] o_vector,
  output logic [3:0] o_push_cnt,
  output logic [7:0] o_push_data,
  output logic o_push_valid,
  output logic o_wake,
  output logic [cfi_pkg::N_SRC-1:0] o_pending
);
  import cfi_pkg::*;

  typedef enum logic [2:0] {CFI_RUN, CFI_PUSH, CFI_VEC} cfi_state_t;

  logic [7:0] condition_flags_r, condition_flags_nxt;
  logic [NSRC-1:0] pend_r, pend_nxt;
  logic [NSRC-1:0] ext_prev_r;
  logic [NSRC-1:0] raw_req;
  logic [NSRC-1:0] grant;
  logic [NSRC-1:0] enabled_req;
  logic [NSRC-1:0] blocked_pre;
  cfi_state_t state_r;
  logic [2:0] push_idx_r;
  logic trap_r;
  logic [NSRC-1:0] sel_r;
  logic [ADDR_W-1:0] vec_r;
  logic nand_req;
  logic mask;
  logic take;
  logic any_req;
  logic [7:0] push_byte;
  // Decodes kept as named wires so the clocked blocks stay short
  logic [NSRC-1:0] src_now;
  logic [NSRC-1:0] pend_kept;
  logic [NSRC-1:0] entry_clr;
  logic [ADDR_W-1:0] src_vec [NSRC];
  logic [ADDR_W-1:0] sel_vec;
  logic [7:0] return_from_isr_instr_flags;
  logic boundary;
  logic unmasked_req;
  logic is_data_op;
  logic in_push;
  logic in_vec;
  logic push_last;
  logic wake_wait;
  logic wake_halt;

  ////////////////////////////////////////////////////////////////////////////
  // [RULE20] NAND group gate
  assign nand_req = ~|(~i_nand_pins & i_nand_irq_cfg) & |i_nand_irq_cfg;
  assign mask = condition_flags_r[BIT_MASK];
  // Bit 7 of the external bus is replaced by the NAND group, so its own
  // pin is not used
  assign src_now = {nand_req, i_ext_irq_source[NSRC-2:0]};

  // [RULE19] Edge or level capture
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      logic src_in;
      assign src_in = src_now[g];
      assign raw_req[g] = EDGE_SRC[g] ? (src_in & ~ext_prev_r[g]) :
                          (src_in | i_periph_flag[g]);
      // [RULE21] Enable gating
      assign enabled_req[g] = pend_r[g] & (EDGE_SRC[g] | i_periph_en[g]);
      // [RULE15] Fixed priority
      if (g == 0) begin : g_p0
        assign blocked_pre[g] = 1'b0;
      end else begin : g_pn
        assign blocked_pre[g] = blocked_pre[g-1] | enabled_req[g-1];
      end
      assign grant[g] = enabled_req[g] & ~blocked_pre[g];
      // [RULE23] Vector table, two bytes per source
      assign src_vec[g] = VEC_BASE + ADDR_W'(2 * g);
    end
  endgenerate

  // [RULE5] Latch while masked
  // [RULE22] Clear discards pending; a new event wins over the clear
  assign pend_kept = pend_r & ~i_periph_clr;
  // [RULE19] Granted edge latches drop on entry; a trap entry clears no latch
  assign entry_clr = (take && !i_trap) ? (grant & EDGE_SRC) : '0;
  always_comb begin
    pend_nxt = (pend_kept & ~entry_clr) | raw_req;
  end

  assign any_req = |enabled_req;
  // [RULE10] Only at an instruction boundary
  assign boundary = (state_r == CFI_RUN) && i_instr_done;
  // [RULE6] [RULE18] Serviced as soon as mask clears
  assign unmasked_req = any_req && !mask;
  // [RULE17] Trap ignores mask
  assign take = boundary && (i_trap || unmasked_req);

  ////////////////////////////////////////////////////////////////////////////
  // State decodes
  // Push runs five cycles, index 0 to 4
  assign in_push = (state_r == CFI_PUSH);
  assign in_vec = (state_r == CFI_VEC);
  assign push_last = (push_idx_r == 3'h4);
  assign is_data_op = (i_op == CFI_OP_ADD) || (i_op == CFI_OP_LOGIC) || (i_op == CFI_OP_SHIFT);
  // [RULE13] Return clears the mask whatever byte was stacked
  assign return_from_isr_instr_flags = i_pop_flags & ~(8'h01 << BIT_MASK);
  // [RULE16] Wait exits on anything; halt only on sources that keep running
  assign wake_wait = i_wait_mode && (any_req || i_trap);
  assign wake_halt = i_halt_mode && |(pend_r & HALT_WAKE);

  ////////////////////////////////////////////////////////////////////////////
  // Flag updates
  always_comb begin
    condition_flags_nxt = condition_flags_r;
    case (i_op)
      CFI_OP_ADD: begin
        // [RULE3] Half carry
        condition_flags_nxt[BIT_HALF] = i_half;
        condition_flags_nxt[BIT_CARRY] = i_carry;
      end
      CFI_OP_SHIFT, CFI_OP_BTJ: condition_flags_nxt[BIT_CARRY] = i_carry;
      // [RULE9] Carry instructions
      CFI_OP_SET_CARRY: condition_flags_nxt[BIT_CARRY] = 1'b1;
      CFI_OP_RESET_CARRY: condition_flags_nxt[BIT_CARRY] = 1'b0;
      // [RULE4] Mask instructions
      CFI_OP_SET_MASK: condition_flags_nxt[BIT_MASK] = 1'b1;
      CFI_OP_CLEAR_MASK: condition_flags_nxt[BIT_MASK] = 1'b0;
      // [RULE2] Whole byte pop
      CFI_OP_POP: condition_flags_nxt = i_pop_flags;
      // [RULE13] Restore with mask clear
      CFI_OP_RETURN_FROM_ISR_INSTR: condition_flags_nxt = return_from_isr_instr_flags;
      default: condition_flags_nxt = condition_flags_r;
    endcase
    if (is_data_op) begin
      // [RULE7] Negative copy
      condition_flags_nxt[BIT_NEG] = i_result[7];
      // [RULE8] Zero detect
      condition_flags_nxt[BIT_ZERO] = (i_result == 8'h00);
    end
    // [RULE12] Mask set on entry
    if (in_vec) begin
      condition_flags_nxt[BIT_MASK] = 1'b1;
    end
    // [RULE1] Upper bits fixed
    condition_flags_nxt = condition_flags_nxt | FLAGS_ONES;
  end

  // [RULE11] Push order: pc low, pc high, index, acc, flags
  always_comb begin
    case (push_idx_r)
      3'h0: push_byte = i_pc[7:0];
      3'h1: push_byte = i_pc[15:8];
      3'h2: push_byte = i_index;
      3'h3: push_byte = i_acc;
      default: push_byte = condition_flags_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // [RULE1] [RULE14] Reset value masks interrupts
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      condition_flags_r <= FLAGS_RESET;
      pend_r <= '0;
    end else begin
      condition_flags_r <= condition_flags_nxt;
      pend_r <= pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge history resets low to match the idle level of the request pins,
  // so no false edge follows reset
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_prev_r <= '0;
    end else begin
      ext_prev_r <= src_now;
    end
  end

  // One-hot select of the granted source; an empty select gives the base
  // vector, which only the trap path can reach and which it overrides
  always_comb begin
    sel_vec = VEC_BASE;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (sel_r[k]) begin
        sel_vec = src_vec[k];
      end
    end
  end

  // [RULE23] Parameterised vectors
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= CFI_RUN;
      push_idx_r <= 3'h0;
      trap_r <= 1'b0;
      sel_r <= '0;
      vec_r <= '0;
    end else begin
      case (state_r)
        CFI_RUN: begin
          if (take) begin
            state_r <= CFI_PUSH;
            push_idx_r <= 3'h0;
            trap_r <= i_trap;
            sel_r <= grant;
          end
        end
        CFI_PUSH: begin
          push_idx_r <= push_idx_r + 3'h1;
          if (push_last) begin
            state_r <= CFI_VEC;
          end
        end
        CFI_VEC: begin
          state_r <= CFI_RUN;
        end
        default: state_r <= CFI_RUN;
      endcase
      vec_r <= trap_r ? TRAP_VEC : sel_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_condition_flags <= FLAGS_RESET;
      o_entry <= 1'b0;
      o_vector <= '0;
      o_push_cnt <= 4'h0;
      o_push_data <= 8'h00;
      o_push_valid <= 1'b0;
      o_wake <= 1'b0;
      o_pending <= '0;
    end else begin
      o_condition_flags <= condition_flags_nxt;
      o_entry <= in_vec;
      o_vector <= vec_r;
      o_push_cnt <= {1'b0, push_idx_r};
      o_push_data <= push_byte;
      o_push_valid <= in_push;
      // [RULE16] Wake from wait on any, halt only designated
      o_wake <= wake_wait || wake_halt;
      o_pending <= pend_r;
    end
  end

endmodule : cfi_core
`default_nettype wire

// File: testbench/cfi_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cfi_core_sva (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire cfi_pkg::cfi_op_t i_op,
  input wire logic [7:0] i_result,
  input wire logic i_half,
  input wire logic i_instr_done,
  input wire logic i_trap,
  input wire logic [7:0] o_condition_flags,
  input wire logic o_entry,
  input wire logic o_push_valid,
  input wire logic [3:0] o_push_cnt
);
  import cfi_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  wire logic idle = !o_push_valid && !o_entry;
  wire logic [7:0] f = o_condition_flags;
  sequence s_save;
    o_push_valid && o_push_cnt == 4'h0 ##1 o_push_valid [*4] ##1 o_entry;
  endsequence
  property p_ones; f[7:5] == 3'h7; endproperty
  a_ones: assert property (p_ones) else $error("upper bits low");
  property p_rst; $rose(i_resetn) |-> f == FLAGS_RESET; endproperty
  a_rst: assert property (p_rst) else $error("bad reset flags");
  property p_take; i_instr_done && i_trap && idle |=> ##1 s_save; endproperty
  a_take: assert property (p_take) else $error("bad entry");
  property p_mask; o_entry |-> f[BIT_MASK]; endproperty
  a_mask: assert property (p_mask) else $error("mask clear at entry");
  property p_hold;
    f[BIT_MASK] && idle && i_instr_done && !i_trap && i_op == CFI_OP_NONE |=> ##1 !o_push_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("masked entry");
  property p_half; i_op == CFI_OP_ADD |=> f[BIT_HALF] == $past(i_half); endproperty
  a_half: assert property (p_half) else $error("bad half carry");
  property p_nz;
    logic [7:0] r;
    (i_op == CFI_OP_LOGIC, r = i_result) |=> f[BIT_NEG] == r[7] && f[BIT_ZERO] == (r == 8'h00);
  endproperty
  a_nz: assert property (p_nz) else $error("bad sign or zero");
  property p_carry; i_op == CFI_OP_SET_CARRY |=> f[BIT_CARRY]; endproperty
  a_carry: assert property (p_carry) else $error("carry not set");
  property p_rim; i_op == CFI_OP_CLEAR_MASK && idle |=> !f[BIT_MASK]; endproperty
  a_rim: assert property (p_rim) else $error("mask not cleared");
endmodule : cfi_core_sva
`default_nettype wire

// File: testbench/cfi_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfi_periph_model (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [7:0] i_ext_req,
  input wire logic [7:0] i_flag_set,
  input wire logic [7:0] i_periph_clr,
  output logic [7:0] o_ext_irq_source,
  output logic [7:0] o_periph_flag,
  output logic [3:0] o_nand_pins
);
  assign o_nand_pins = 4'hf;
  assign o_ext_irq_source = i_ext_req;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) o_periph_flag <= 8'h00;
    else o_periph_flag <= (o_periph_flag | i_flag_set) & ~i_periph_clr;
  end
endmodule : cfi_periph_model
`default_nettype wire

// File: testbench/cfi_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module cfi_core_test;
  import cfi_pkg::*;
  localparam logic [15:0] VB = 16'hffe0;
  localparam logic [15:0] TV = 16'hfffc;
  logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_instr_done = 1'b0, i_trap = 1'b0, i_carry = 1'b0;
  logic i_half = 1'b0, i_wait_mode = 1'b0, i_halt_mode = 1'b0, o_entry, o_push_valid, o_wake;
  cfi_op_t i_op = CFI_OP_NONE;
  logic [7:0] i_result = 8'h00, i_pop_flags = 8'h00, i_index = 8'h56, i_acc = 8'h78;
  logic [7:0] i_periph_en = 8'hff, i_periph_clr = 8'h00, ext_req = 8'h00, flag_set = 8'h00;
  logic [7:0] i_ext_irq_source, i_periph_flag, o_condition_flags, o_push_data, o_pending;
  logic [15:0] i_pc = 16'h1234, o_vector;
  logic [3:0] i_nand_irq_cfg = 4'h0, i_nand_pins, o_push_cnt;
  int fail_count = 0, check_count = 0;
  initial forever #50 i_clk_sys = ~i_clk_sys;
  cfi_core #(.VEC_BASE(VB), .TRAP_VEC(TV)) i_dut (.i_clk_sys, .i_resetn, .i_op, .i_result,
    .i_carry, .i_half, .i_pop_flags, .i_instr_done, .i_trap, .i_wait_mode, .i_halt_mode,
    .i_ext_irq_source, .i_nand_pins, .i_nand_irq_cfg, .i_periph_flag, .i_periph_en,
    .i_periph_clr, .i_pc, .i_index, .i_acc, .o_condition_flags, .o_entry, .o_vector,
    .o_push_cnt, .o_push_data, .o_push_valid, .o_wake, .o_pending);
  cfi_periph_model i_far (.i_clk_sys, .i_resetn, .i_ext_req(ext_req), .i_flag_set(flag_set),
    .i_periph_clr, .o_ext_irq_source(i_ext_irq_source), .o_periph_flag(i_periph_flag),
    .o_nand_pins(i_nand_pins));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic run(input cfi_op_t op, input logic d, input logic t);
    @(negedge i_clk_sys);
    i_op = op;
    i_instr_done = d;
    i_trap = t;
    @(negedge i_clk_sys);
    i_op = CFI_OP_NONE;
    i_instr_done = 1'b0;
    i_trap = 1'b0;
  endtask : run
  // Waits for the context bytes, then the vector
  task automatic take(input logic [15:0] vec, input logic [7:0] fl);
    logic [7:0] b [5];
    int n;
    b = '{i_pc[7:0], i_pc[15:8], i_index, i_acc, fl};
    n = 0;
    while (o_push_valid !== 1'b1 && n < 8) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n == 8) begin
      fail_count++;
      report_and_stop;
    end else begin
      for (int k = 0; k < 5; k++) begin
        chk(o_push_cnt, k);
        chk(o_push_data, b[k]);
        @(negedge i_clk_sys);
      end
      chk(o_entry, 1'b1);
      chk(o_vector, vec);
    end
  endtask : take
  initial begin
    repeat (5) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    @(negedge i_clk_sys);
    chk(o_condition_flags, 8'he8);
    i_result = 8'h80;
    i_carry = 1'b1;
    i_half = 1'b1;
    run(CFI_OP_ADD, 1'b0, 1'b0);
    chk(o_condition_flags, 8'hfd);
    i_result = 8'h00;
    run(CFI_OP_LOGIC, 1'b0, 1'b0);
    chk(o_condition_flags & 8'h06, 8'h02);
    run(CFI_OP_RESET_CARRY, 1'b0, 1'b0);
    chk(o_condition_flags[BIT_CARRY], 1'b0);
    run(CFI_OP_BTJ, 1'b0, 1'b0);
    chk(o_condition_flags[BIT_CARRY], 1'b1);
    i_pop_flags = 8'h05;
    run(CFI_OP_POP, 1'b0, 1'b0);
    chk(o_condition_flags, 8'he5);
    run(CFI_OP_SET_MASK, 1'b0, 1'b0);
    ext_req = 8'h02;
    flag_set = 8'h08;
    run(CFI_OP_NONE, 1'b1, 1'b0);
    repeat (2) @(negedge i_clk_sys);
    flag_set = 8'h00;
    chk(o_push_valid, 1'b0);
    chk(o_pending & 8'h0a, 8'h0a);
    run(CFI_OP_CLEAR_MASK, 1'b0, 1'b0);
    run(CFI_OP_NONE, 1'b1, 1'b0);
    take(VB + 16'h0002, 8'he5);
    chk(o_pending[1], 1'b0);
    i_pc = 16'hbeef;
    run(CFI_OP_CLEAR_MASK, 1'b0, 1'b0);
    run(CFI_OP_NONE, 1'b1, 1'b0);
    take(VB + 16'h0006, 8'he5);
    i_periph_clr = 8'h08;
    repeat (2) @(negedge i_clk_sys);
    i_periph_clr = 8'h00;
    @(negedge i_clk_sys);
    chk(o_pending[3], 1'b0);
    i_pop_flags = 8'h00;
    run(CFI_OP_RETURN_FROM_ISR_INSTR, 1'b0, 1'b0);
    chk(o_condition_flags, 8'he0);
    run(CFI_OP_SET_MASK, 1'b0, 1'b0);
    run(CFI_OP_NONE, 1'b1, 1'b1);
    take(TV, 8'he8);
    i_halt_mode = 1'b1;
    ext_req = 8'h03;
    repeat (6) @(negedge i_clk_sys);
    chk(o_wake, 1'b1);
    report_and_stop;
  end
endmodule : cfi_core_test
bind cfi_core cfi_core_sva i_sva (.i_clk_sys, .i_resetn, .i_op, .i_result, .i_half,
  .i_instr_done, .i_trap, .o_condition_flags, .o_entry, .o_push_valid, .o_push_cnt);
`default_nettype wire
